// File: include/dbss_pkg.sv
/*
  Shared constants and carriers for the dynamic bus sizing sequencer.
  Assumes one bus clock; acknowledges are active low on the pins.
*/
package dbss_pkg;
  localparam int ADDR_W  = 24;
  localparam int SPACE_W = 3;

  // Transfer size codes driven with each bus cycle
  localparam logic [1:0] SIZE_LONG  = 2'h0;
  localparam logic [1:0] SIZE_BYTE  = 2'h1;
  localparam logic [1:0] SIZE_WORD  = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;

  // Acknowledge patterns, bit 1 is port16_ack, bit 0 is port8_ack
  localparam logic [1:0] ACK_IDLE  = 2'h3;
  localparam int         ACK16_BIT = 1;

  // Bytes still to move in the current operand piece
  localparam logic [2:0] REM_NONE  = 3'h0;
  localparam logic [2:0] REM_BYTE  = 3'h1;
  localparam logic [2:0] REM_WORD  = 3'h2;
  localparam logic [2:0] REM_THREE = 3'h3;
  localparam logic [2:0] REM_LONG  = 3'h4;
  localparam logic [2:0] TAKE_ONE  = 3'h1;
  localparam logic [2:0] TAKE_TWO  = 3'h2;

  localparam logic [15:0]        DATA_RST  = 16'h0000;
  localparam logic [31:0]        WORD_RST  = 32'h00000000;
  localparam logic [SPACE_W-1:0] SPACE_RST = 3'h0;

  typedef enum logic [1:0] {
    DBSS_LEN_BYTE,
    DBSS_LEN_WORD,
    DBSS_LEN_LONG,
    DBSS_LEN_BAD
  } dbss_len_t;

  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    dbss_len_t          len;
    logic               rnw;
    logic [SPACE_W-1:0] space_code;
    logic [31:0]        wdata;
  } dbss_req_t;

  typedef struct packed {
    logic               strobe;
    logic [ADDR_W-1:0]  addr;
    logic [1:0]         transfer_size_code;
    logic               rnw;
    logic [SPACE_W-1:0] space_code;
  } dbss_bus_t;
endpackage

// File: src/dbss_lane_steer.sv
/*
  Read lane capture and byte consumption for one acknowledged bus cycle.
  Assumes the acknowledge pattern is already synchronised and not idle.
*/
`timescale 1ns/1ps
module dbss_lane_steer (
  input  wire logic [1:0]  i_port_width_ack,
  input  wire logic [2:0]  i_rem,
  input  wire logic        i_addr_lsb,
  input  wire logic [15:0] i_data,
  input  wire logic [31:0] i_rd_acc,
  input  wire logic [31:0] i_wr_acc,
  output logic      [2:0]  o_take,
  output logic      [31:0] o_rd_acc,
  output logic      [31:0] o_wr_acc
);
  logic       port16;
  logic       odd16;
  logic       wide;
  logic [7:0] rd_byte;

  // Port width comes only from this cycle's acknowledge
  assign port16 = ~i_port_width_ack[dbss_pkg::ACK16_BIT]; // [RL23]
  assign odd16  = port16 & i_addr_lsb;
  // Full word only for an even address with two or more bytes left
  assign wide   = port16 & ~i_addr_lsb & (i_rem >= dbss_pkg::REM_WORD); // [RL12]
  assign o_take = wide ? dbss_pkg::TAKE_TWO : dbss_pkg::TAKE_ONE;
  // Odd 16-bit cycles use the lower lane, all others the upper lane
  assign rd_byte = odd16 ? i_data[7:0] : i_data[15:8]; // [RL2] [RL4] [RL6] [RL11] [RL14]
  assign o_rd_acc = wide ? {i_rd_acc[15:0], i_data} : {i_rd_acc[23:0], rd_byte}; // [RL10] [RL16]
  assign o_wr_acc = wide ? {i_wr_acc[15:0], 16'h0000} : {i_wr_acc[23:0], 8'h00}; // [RL9] [RL17]
endmodule

// File: src/dbss_pin_sync.sv
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes the pin is asynchronous to i_clk; the reset value is a constant.
*/
`timescale 1ns/1ps
module dbss_pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  logic         agree;

  if (W < 1) begin : g_bad_w
    $error("dbss_pin_sync width must be at least one");
  end

  // Only the second and third stages are compared; the first is metastable-prone
  assign agree = (s2_q == s3_q);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_q  <= RST_VAL;
      s2_q  <= RST_VAL;
      s3_q  <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign o_level = lvl_q;
endmodule

// File: src/dbss_sequencer.sv
/*
  Dynamic bus sizing sequencer: splits byte, word and long operands into
  one to four bus cycles, adapting to the width each acknowledge reports.
  Assumes a slave that holds acknowledge until the strobe falls, and a
  requester on i_clk that waits for o_req_ready.
*/
// Behaviour
// [RL1] Byte operand uses byte size code; either address parity; bytes at consecutive addresses.
// [RL2] Byte read from 8-bit port takes upper lane, ignores lower lane.
// [RL3] Byte write copies the byte to both lanes; 8-bit slave stores upper.
// [RL4] Byte read, 16-bit port, even address: upper lane only.
// [RL5] Byte write, 16-bit port, even address: slave stores upper lane.
// [RL6] Byte read, 16-bit port, odd address: lower lane only.
// [RL7] Byte write, 16-bit port, odd address: slave stores lower lane.
// [RL8] Byte-writable 16-bit memory is built from 8-bit banks with own selects.
// [RL9] Aligned word write to 8-bit port: both bytes, then low byte moves up.
// [RL10] Word read from 8-bit port: high byte, then low byte from upper lane.
// [RL11] Misaligned word to 8-bit port: two byte cycles, upper lane first.
// [RL12] Aligned word read from 16-bit port finishes in one cycle, all bits.
// [RL13] Aligned word write to 16-bit port drives the whole word.
// [RL14] Misaligned word read, 16-bit port: lower lane first, then upper lane.
// [RL15] Misaligned word write, 16-bit port: each byte on both lanes.
// [RL16] Aligned long to 8-bit port: four byte cycles, sizes long, three, word, byte.
// [RL17] Aligned long write to 8-bit port: top two bytes first, then shift up.
// [RL18] Three-byte size code only appears as a long-word continuation.
// [RL19] Misaligned long splits into two misaligned words, or is refused entirely.
// [RL20] Space code and direction accompany address and size on every cycle.
// [RL21] Size codes: byte 01, word 10, three-byte 11, long 00.
// [RL22] Slave reports width: pattern 10 is 8-bit, 01 is 16-bit.
// [RL23] Follow-on cycles depend only on each cycle's sampled acknowledge.
`timescale 1ns/1ps
module dbss_sequencer #(
  parameter int ALLOW_MISALIGN = 1
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  input  wire logic                i_req_valid,
  input  wire dbss_pkg::dbss_req_t i_req,
  output logic                     o_req_ready,
  output logic                     o_done,
  output logic                     o_err,
  output logic [31:0]              o_rdata,
  output dbss_pkg::dbss_bus_t      o_bus,
  output logic [15:0]              o_data,
  output logic                     o_data_oe,
  input  wire logic [15:0]         i_data,
  input  wire logic [1:0]          i_port_width_ack
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_ACK,
    ST_WAIT_NEG
  } dbss_state_t;

  if (ALLOW_MISALIGN != 0 && ALLOW_MISALIGN != 1) begin : g_bad_mis
    $error("ALLOW_MISALIGN must be 0 or 1");
  end

  dbss_state_t         state_q;
  dbss_state_t         state_d;
  dbss_pkg::dbss_bus_t bus_q;
  dbss_pkg::dbss_bus_t bus_d;
  logic [2:0]          rem_q;
  logic [2:0]          rem_d;
  logic                pend_q;
  logic                pend_d;
  logic [dbss_pkg::ADDR_W-1:0] nxt_addr_q;
  logic [dbss_pkg::ADDR_W-1:0] nxt_addr_d;
  logic [31:0]         rd_q;
  logic [31:0]         rd_d;
  logic [31:0]         wr_q;
  logic [31:0]         wr_d;
  logic [15:0]         dout_q;
  logic [15:0]         dout_d;
  logic                doe_q;
  logic                doe_d;
  logic                ready_q;
  logic                ready_d;
  logic                done_q;
  logic                done_d;
  logic                err_q;
  logic                err_d;
  logic [31:0]         rdata_q;
  logic [31:0]         rdata_d;

  logic [1:0]          ack_s;
  logic [15:0]         data_s;
  logic [2:0]          take;
  logic [31:0]         rd_step;
  logic [31:0]         wr_step;

  // Size code from the bytes still owed
  function automatic logic [1:0] size_of(input logic [2:0] rem);
    unique case (rem)
      dbss_pkg::REM_BYTE:  size_of = dbss_pkg::SIZE_BYTE;
      dbss_pkg::REM_WORD:  size_of = dbss_pkg::SIZE_WORD;
      dbss_pkg::REM_THREE: size_of = dbss_pkg::SIZE_THREE;
      default:             size_of = dbss_pkg::SIZE_LONG;
    endcase
  endfunction

  // Lanes for a write cycle: the pair when aligned with two or more bytes left, else the next byte twice
  function automatic logic [15:0] lanes_of(
    input logic [31:0] wr,
    input logic [2:0]  rem,
    input logic        lsb
  );
    if (rem >= dbss_pkg::REM_WORD && !lsb) begin
      lanes_of = wr[31:16];
    end else begin
      lanes_of = {wr[31:24], wr[31:24]};
    end
  endfunction

  // Acknowledge and data come from outside the clock domain
  dbss_pin_sync #(
    .W       (2),
    .RST_VAL (dbss_pkg::ACK_IDLE)
  ) u_ack_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pin   (i_port_width_ack),
    .o_level (ack_s)
  );

  // Data passes the same depth so it is settled when the acknowledge is seen
  dbss_pin_sync #(
    .W       (16),
    .RST_VAL (dbss_pkg::DATA_RST)
  ) u_data_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pin   (i_data),
    .o_level (data_s)
  );

  dbss_lane_steer u_steer (
    .i_port_width_ack (ack_s),
    .i_rem            (rem_q),
    .i_addr_lsb       (bus_q.addr[0]),
    .i_data           (data_s),
    .i_rd_acc         (rd_q),
    .i_wr_acc         (wr_q),
    .o_take           (take),
    .o_rd_acc         (rd_step),
    .o_wr_acc         (wr_step)
  );

  // Request decode
  logic        req_take;
  logic        req_mis;
  logic        req_bad;
  logic        req_split;
  logic [2:0]  req_rem;
  logic [2:0]  req_first;
  logic [31:0] req_wr;
  logic        ack_seen;
  logic        ack_gone;
  logic        more;
  logic [2:0]  cont_rem;

  assign req_take = ready_q & i_req_valid;
  // Word and long parity matters; a byte may sit at either address
  assign req_mis  = i_req.addr[0] & (i_req.len != dbss_pkg::DBSS_LEN_BYTE); // [RL1]
  // No request can ask for three bytes, and misalignment needs the variant
  assign req_bad  = (i_req.len == dbss_pkg::DBSS_LEN_BAD) // [RL18]
                  | (req_mis & (ALLOW_MISALIGN == 0)); // [RL19]
  assign req_split = req_mis & (i_req.len == dbss_pkg::DBSS_LEN_LONG); // [RL19]
  assign req_rem  = (i_req.len == dbss_pkg::DBSS_LEN_LONG) ? dbss_pkg::REM_LONG :
                    (i_req.len == dbss_pkg::DBSS_LEN_WORD) ? dbss_pkg::REM_WORD :
                    dbss_pkg::REM_BYTE;
  // A split long starts as a misaligned word
  assign req_first = req_split ? dbss_pkg::REM_WORD : req_rem;
  // Operand is left-justified so the next byte is always at the top
  assign req_wr   = (i_req.len == dbss_pkg::DBSS_LEN_LONG) ? i_req.wdata :
                    (i_req.len == dbss_pkg::DBSS_LEN_WORD) ? {i_req.wdata[15:0], 16'h0000} :
                    {i_req.wdata[7:0], 24'h000000};

  assign ack_seen = (ack_s != dbss_pkg::ACK_IDLE); // [RL22]
  assign ack_gone = (ack_s == dbss_pkg::ACK_IDLE);
  assign more     = (rem_q != dbss_pkg::REM_NONE) | pend_q;
  // Second half of a split long is another two-byte word
  assign cont_rem = (rem_q != dbss_pkg::REM_NONE) ? rem_q : dbss_pkg::REM_WORD; // [RL19]

  always_comb begin
    state_d    = state_q;
    bus_d      = bus_q;
    rem_d      = rem_q;
    pend_d     = pend_q;
    nxt_addr_d = nxt_addr_q;
    rd_d       = rd_q;
    wr_d       = wr_q;
    dout_d     = dout_q;
    doe_d      = doe_q;
    ready_d    = ready_q;
    done_d     = 1'b0;
    err_d      = 1'b0;
    rdata_d    = rdata_q;
    unique case (state_q)
      ST_IDLE: begin
        if (req_take && req_bad) begin
          done_d = 1'b1;
          err_d  = 1'b1;
        end else if (req_take) begin
          ready_d                  = 1'b0;
          bus_d.strobe             = 1'b1;
          bus_d.addr               = i_req.addr; // [RL1]
          bus_d.transfer_size_code = size_of(req_first); // [RL21]
          bus_d.rnw                = i_req.rnw; // [RL20]
          bus_d.space_code         = i_req.space_code; // [RL20]
          rem_d                    = req_first;
          pend_d                   = req_split;
          rd_d                     = dbss_pkg::WORD_RST;
          wr_d                     = req_wr;
          // Byte copied to both lanes, aligned pair drives all 16 bits
          dout_d                   = lanes_of(req_wr, req_first, i_req.addr[0]); // [RL3] [RL13] [RL15]
          doe_d                    = ~i_req.rnw;
          state_d                  = ST_WAIT_ACK;
        end
      end
      ST_WAIT_ACK: begin
        if (ack_seen) begin
          // Width is learnt here, every cycle afresh
          bus_d.strobe = 1'b0; // [RL23]
          rem_d        = 3'(rem_q - take); // [RL9] [RL10] [RL14] [RL16]
          nxt_addr_d   = bus_q.addr + {{(dbss_pkg::ADDR_W - 3){1'b0}}, take}; // [RL1] [RL16]
          rd_d         = rd_step;
          wr_d         = wr_step; // [RL9] [RL17]
          state_d      = ST_WAIT_NEG;
        end
      end
      ST_WAIT_NEG: begin
        // Address, size and data hold until the slave releases its acknowledge
        if (ack_gone && more) begin
          bus_d.strobe             = 1'b1;
          bus_d.addr               = nxt_addr_q;
          bus_d.transfer_size_code = size_of(cont_rem); // [RL16] [RL18] [RL21]
          rem_d                    = cont_rem;
          pend_d                   = (rem_q != dbss_pkg::REM_NONE) & pend_q;
          dout_d                   = lanes_of(wr_q, cont_rem, nxt_addr_q[0]); // [RL9] [RL15] [RL17]
          state_d                  = ST_WAIT_ACK;
        end else if (ack_gone) begin
          doe_d   = 1'b0;
          ready_d = 1'b1;
          done_d  = 1'b1;
          rdata_d = rd_q;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // One short block per register group keeps each reset value beside its update
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Bus resets to a byte read so a stray strobe could not write; after a cycle it keeps that cycle's fields
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bus_q <= '{strobe: 1'b0, addr: '0, transfer_size_code: dbss_pkg::SIZE_BYTE,
                 rnw: 1'b1, space_code: dbss_pkg::SPACE_RST};
    end else begin
      bus_q <= bus_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rem_q <= dbss_pkg::REM_NONE;
    end else begin
      rem_q <= rem_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nxt_addr_q <= '0;
    end else begin
      nxt_addr_q <= nxt_addr_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_q <= dbss_pkg::WORD_RST;
      wr_q <= dbss_pkg::WORD_RST;
    end else begin
      rd_q <= rd_d;
      wr_q <= wr_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dout_q <= dbss_pkg::DATA_RST;
      doe_q  <= 1'b0;
    end else begin
      dout_q <= dout_d;
      doe_q  <= doe_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      done_q <= done_d;
      err_q  <= err_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= dbss_pkg::WORD_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Every output is a register, so pins never glitch on decode
  assign o_req_ready = ready_q;
  assign o_done      = done_q;
  assign o_err       = err_q;
  assign o_rdata     = rdata_q;
  assign o_bus       = bus_q;
  assign o_data      = dout_q;
  assign o_data_oe   = doe_q;
endmodule

// File: verif/dbss_sequencer_sva.sv
/*
  Port checker for the dynamic bus sizing sequencer.
  Assumes one clock and an active-low asynchronous reset; bound to the top module.
*/
`timescale 1ns/1ps
module dbss_sequencer_sva #(
  parameter int ALLOW_MISALIGN = 1
) (
  input wire logic                i_clk,
  input wire logic                i_rst_b,
  input wire logic                i_req_valid,
  input wire dbss_pkg::dbss_req_t i_req,
  input wire logic                o_req_ready,
  input wire logic                o_done,
  input wire logic                o_err,
  input wire logic [31:0]         o_rdata,
  input wire dbss_pkg::dbss_bus_t o_bus,
  input wire logic [15:0]         o_data,
  input wire logic                o_data_oe,
  input wire logic [15:0]         i_data,
  input wire logic [1:0]          i_port_width_ack
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  wire logic       take_w = i_req_valid && o_req_ready;
  wire logic       odd_w  = i_req.addr[0] && i_req.len != dbss_pkg::DBSS_LEN_BYTE;
  wire logic       bad_w  = i_req.len == dbss_pkg::DBSS_LEN_BAD || (ALLOW_MISALIGN == 0 && odd_w);
  // Misaligned long opens as a word piece
  wire logic [1:0] sz_w   = i_req.len == dbss_pkg::DBSS_LEN_BYTE ? dbss_pkg::SIZE_BYTE :
                            (i_req.len == dbss_pkg::DBSS_LEN_LONG && !i_req.addr[0]) ? dbss_pkg::SIZE_LONG :
                            dbss_pkg::SIZE_WORD;

  first_cycle_a: assert property (take_w && !bad_w |=> o_bus.strobe && o_bus.addr == $past(i_req.addr)
    && o_bus.rnw == $past(i_req.rnw) && o_bus.space_code == $past(i_req.space_code)) else $error("first cycle fields");
  first_size_a: assert property (take_w && !bad_w |=> o_bus.transfer_size_code == $past(sz_w))
    else $error("first cycle size code");
  refuse_bad_a: assert property (take_w && bad_w |=> o_done && o_err && o_req_ready && !o_bus.strobe)
    else $error("refusal");
  cycle_hold_a: assert property (o_bus.strobe && $past(o_bus.strobe) |-> $stable(o_bus) && $stable(o_data))
    else $error("bus changed mid cycle");
  ack_wait_a: assert property ($rose(o_bus.strobe) |=> o_bus.strobe [*2])
    else $error("strobe ended before sync");
  ack_end_a: assert property (o_bus.strobe && i_port_width_ack != 2'h3 |-> ##[1:8] !o_bus.strobe)
    else $error("ack not honoured");
  gap_min_a: assert property ($fell(o_bus.strobe) |-> !o_bus.strobe [*2])
    else $error("cycle reopened early");
  byte_lanes_a: assert property (o_bus.strobe && !o_bus.rnw
    && (o_bus.transfer_size_code == dbss_pkg::SIZE_BYTE || o_bus.addr[0]) |-> o_data[15:8] == o_data[7:0])
    else $error("single byte not on both lanes");
  drive_dir_a: assert property (o_bus.strobe |-> o_data_oe == !o_bus.rnw)
    else $error("data enable wrong");
  done_pair_a: assert property (o_err |-> o_done && o_req_ready)
    else $error("err without done");
endmodule

bind dbss_sequencer dbss_sequencer_sva #(.ALLOW_MISALIGN(ALLOW_MISALIGN)) sva_u (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
  .o_done(o_done), .o_err(o_err), .o_rdata(o_rdata), .o_bus(o_bus), .o_data(o_data), .o_data_oe(o_data_oe),
  .i_data(i_data), .i_port_width_ack(i_port_width_ack)
);

// File: verif/dbss_sequencer_test.sv
/*
  Self-checking bench: write then read back every size and parity on both port widths.
  Assumes the slave model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module dbss_sequencer_test;
  logic                i_clk       = 1'b0;
  logic                i_rst_b     = 1'b0;
  logic                i_req_valid = 1'b0;
  dbss_pkg::dbss_req_t i_req       = '0;
  logic                o_req_ready, o_done, o_err, o_data_oe;
  logic [31:0]         o_rdata;
  dbss_pkg::dbss_bus_t o_bus;
  logic [15:0]         o_data, i_data;
  logic [1:0]          i_port_width_ack;
  logic                wide  = 1'b0;
  logic [3:0]          delay = 4'h0;
  int                  seed  = 62;
  int                  error_cnt = 0;
  int                  tests_run = 0;
  int                  cyc = 0;
  logic [33:0]         exp_q [$];
  logic [33:0]         e;
  logic [8:0]          exp_mem [256] = '{default: 9'h0};
  logic                strict_valid = 1'b0;
  logic                strict_done, strict_err;

  always #5 i_clk = ~i_clk;

  dbss_sequencer #(.ALLOW_MISALIGN(1)) dut_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
    .o_done(o_done), .o_err(o_err), .o_rdata(o_rdata), .o_bus(o_bus), .o_data(o_data), .o_data_oe(o_data_oe),
    .i_data(i_data), .i_port_width_ack(i_port_width_ack)
  );
  // Variant without misalignment support; it only ever sees refused requests
  dbss_sequencer #(.ALLOW_MISALIGN(0)) strict_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(strict_valid), .i_req(i_req), .o_req_ready(),
    .o_done(strict_done), .o_err(strict_err), .o_rdata(), .o_bus(), .o_data(), .o_data_oe(),
    .i_data(i_data), .i_port_width_ack(i_port_width_ack)
  );
  dbss_slave_model slave_u (
    .i_clk(i_clk), .i_bus(o_bus), .i_data(o_data), .i_wide(wide), .i_delay(delay), .o_data(i_data),
    .o_ack(i_port_width_ack)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      error_cnt++;
      $display("Error %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic results();
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Valid stays high after a take so the next request lands on the done edge
  task automatic xfer(input logic [23:0] a, input dbss_pkg::dbss_len_t l, input logic rnw, input logic [31:0] wd);
    int n;
    n = (l == dbss_pkg::DBSS_LEN_BYTE) ? 1 : (l == dbss_pkg::DBSS_LEN_WORD) ? 2 : 4;
    i_req = '{addr: a, len: l, rnw: rnw, space_code: wd[2:0] ^ 3'h5, wdata: wd};
    i_req_valid = 1'b1;
    if (l == dbss_pkg::DBSS_LEN_BAD) exp_q.push_back({2'b01, 32'h0});
    else if (rnw) exp_q.push_back({2'b10, (n == 4) ? wd : (n == 2) ? {16'h0, wd[15:0]} : {24'h0, wd[7:0]}});
    else begin
      exp_q.push_back({2'b00, 32'h0});
      for (int i = 0; i < n; i++) exp_mem[a[7:0] + i] = {1'b1, wd[8*(n-1-i) +: 8]};
    end
    @(posedge i_clk);
    while (!o_req_ready) @(posedge i_clk);
    #1;
  endtask

  always @(negedge i_clk) begin
    if (i_rst_b && o_done === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else begin
        e = exp_q.pop_front();
        check({31'h0, o_err}, {31'h0, e[32]});
        if (e[33]) check(o_rdata, e[31:0]);
      end
    end
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    logic [23:0] a;
    logic [31:0] wd;
    repeat (5) @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    for (int w = 0; w < 2; w++) begin
      wide = w[0];
      // Every size against both address parities, twice per width
      for (int k = 0; k < 12; k++) begin
        a = 24'(w * 96 + k * 8 + k % 2);
        wd = $random(seed);
        delay = 4'($unsigned($random(seed)) % 4);
        xfer(a, dbss_pkg::dbss_len_t'(k % 3), 1'b0, wd);
        xfer(a, dbss_pkg::dbss_len_t'(k % 3), 1'b1, wd);
      end
      xfer(24'h0, dbss_pkg::DBSS_LEN_BAD, 1'b1, 32'h0);
      i_req_valid = 1'b0;
      while (exp_q.size() != 0) @(posedge i_clk);
      #1;
    end
    // Strict variant must refuse a misaligned word at once, with no bus cycle
    i_req = '{addr: 24'h000031, len: dbss_pkg::DBSS_LEN_WORD, rnw: 1'b1, space_code: 3'h1, wdata: 32'h0};
    strict_valid = 1'b1;
    @(posedge i_clk);
    #1 strict_valid = 1'b0;
    check({30'h0, strict_done, strict_err}, 32'h3);
    for (int i = 0; i < 256; i++)
      if (exp_mem[i][8]) check({24'h0, slave_u.mem[i]}, 32'(exp_mem[i][7:0]));
    results();
  end
endmodule

// File: verif/dbss_slave_model.sv
/*
  Behavioural 8-bit or 16-bit memory port on the far side of the sequencer.
  Assumes the bench picks the width and the wait only while the bus is idle.
*/
`timescale 1ns/1ps
module dbss_slave_model (
  input  wire logic                i_clk,
  input  wire dbss_pkg::dbss_bus_t i_bus,
  input  wire logic [15:0]         i_data,
  input  wire logic                i_wide,
  input  wire logic [3:0]          i_delay,
  output logic      [15:0]         o_data,
  output logic      [1:0]          o_ack
);
  logic [7:0] mem [0:255];
  logic [7:0] a;
  initial begin
    o_ack  = 2'h3;
    o_data = 16'hA5A5;
    forever begin
      @(posedge i_clk);
      #1;
      if (i_bus.strobe) begin
        a = i_bus.addr[7:0];
        repeat (i_delay) @(posedge i_clk);
        if (!i_bus.rnw) begin
          if (!i_wide || !a[0]) mem[a] = i_data[15:8];
          else mem[a] = i_data[7:0];
          if (i_wide && !a[0] && i_bus.transfer_size_code != dbss_pkg::SIZE_BYTE) begin
            mem[a + 8'h1] = i_data[7:0];
          end
        end else if (i_wide && a[0]) o_data = {~mem[a], mem[a]};
        else o_data = {mem[a], i_wide ? mem[a + 8'h1] : ~mem[a]};
        // Data leads ack so the three-flop data sync has settled first
        repeat (2) @(posedge i_clk);
        #1 o_ack = i_wide ? 2'h1 : 2'h2;
        while (i_bus.strobe) begin
          @(posedge i_clk);
          #1;
        end
        o_ack  = 2'h3;
        o_data = ~o_data;
      end
    end
  end
endmodule
